/* File: verilog/pause_fc_pkg.sv */
// constants, register map and types for the pause-frame flow-control block
package pause_fc_pkg;
    // ----------------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 5000;                            // 200 MHz
    localparam int QUANTUM_PS      = 51_200_000;                      // 51.2 us, 512 bit times
    localparam int QUANTUM_CYCLES  = QUANTUM_PS / CLK_PERIOD_PS;      // exact, 10240
    localparam int PERIOD_SHIFT    = 1;                               // resend at half the pause time

    // ----------------------------------------------------------------------
    // register map (index on the register port)
    // ----------------------------------------------------------------------
    localparam int         ADDR_W           = 3;
    localparam logic [2:0] ADDR_FLOW_CTRL   = 3'h0;
    localparam logic [2:0] ADDR_ETH_CTRL1   = 3'h1;
    localparam logic [2:0] ADDR_MAC_CTRL1   = 3'h2;
    localparam logic [2:0] ADDR_B2B_GAP     = 3'h3;
    localparam logic [2:0] ADDR_PAUSE_LO    = 3'h4;
    localparam logic [2:0] ADDR_PAUSE_HI    = 3'h5;
    localparam logic [7:0] REG_RESET        = 8'h00;
    localparam logic [7:0] GAP_FIELD_MASK   = 8'h7F;

    // field positions
    localparam int FC_SHADOW_BIT    = 2;
    localparam int FC_SEL_HI_BIT    = 1;
    localparam int FC_SEL_LO_BIT    = 0;
    localparam int ECON_TX_REQ_BIT  = 3;
    localparam int MACON_PAUSE_TRANSMIT_ENABLE_BIT = 3;
    localparam int MACON_PAUSE_RECEIVE_ENABLE_BIT = 2;
    localparam int MACON_FWD_BIT    = 1;

    // flow selector codes in full duplex
    localparam logic [1:0] SEL_OFF      = 2'h0;
    localparam logic [1:0] SEL_ONE      = 2'h1;
    localparam logic [1:0] SEL_PERIODIC = 2'h2;
    localparam logic [1:0] SEL_ZERO     = 2'h3;

    // ----------------------------------------------------------------------
    // pause frame layout (crc appended by the mac makes 64 bytes)
    // ----------------------------------------------------------------------
    localparam logic [5:0]  FRAME_BYTES = 6'h3C;
    localparam logic [47:0] PAUSE_DEST  = 48'h0180C2000001;
    localparam logic [15:0] CTRL_TYPE   = 16'h8808;
    localparam logic [15:0] PAUSE_OP    = 16'h0001;
    localparam logic [5:0]  OFS_SRC     = 6'h06;
    localparam logic [5:0]  OFS_TYPE    = 6'h0C;
    localparam logic [5:0]  OFS_OP      = 6'h0E;
    localparam logic [5:0]  OFS_VAL     = 6'h10;
    localparam logic [5:0]  OFS_PAD     = 6'h12;

    typedef enum logic {PF_IDLE, PF_SEND} pf_state_e;
endpackage

/* File: verilog/pause_frame_flow_control.sv */
// pause-frame flow control: pause generation, pause timer, half-duplex jam
// What this block does
// - sent pause frames: 64 bytes, 01-80-C2-00-00-01, own source, opcode, value, pad
// - after an accepted pause, the current frame finishes, no new host frame starts
// - received value loads pause counter, decremented every 512 bit times
// - reception goes on during a pause; only transmit is held
// - a further pause frame reloads the counter with its own value
// - transmit resumes at counter zero or on a zero-value pause frame
// - writing 02h sends pause frames periodically with the programmed value
// - periodic pause frames never block or corrupt host frames
// - writing 03h sends exactly one last pause frame with value 0000h
// - with pause-receive on and the full-duplex config bit set, a nonzero pause frame inhibits transmit by itself
// - a request while paused waits; request bit clears only after sending
// - with forward set, received pause frames are also handed to the host
// - flow-control bit 2 reads the full-duplex configuration bit
// - full duplex: 11 zero frame once, 10 periodic, 01 once, 00 off
// - half duplex: only the low selector bit turns flow control on
// - pause value lives in separate low and high byte registers
// - flow-control bits 7..3 read 0; selector resets to 0, shadow follows the full-duplex config bit
// - half-duplex flow control jams 55h, pausing for own frame only
`timescale 1ns/1ps
module pause_frame_flow_control
    import pause_fc_pkg::*;
#(
    parameter int QUANTUM_CYC = QUANTUM_CYCLES   // cycles per pause quantum
) (
    input  wire logic                        ref_clk,              // 200 MHz clock
    input  wire logic                        sys_rst,              // sync reset, high
    input  wire logic                        reg_wr,               // register write strobe
    input  wire logic [pause_fc_pkg::ADDR_W-1:0] reg_addr,         // register index
    input  wire logic [7:0]                  reg_wdata,            // write data
    output logic      [7:0]                  reg_rdata,            // read data, registered
    input  wire logic                        mac_full_duplex_cfg,  // full-duplex config bit
    input  wire logic [47:0]                 own_mac_addr,         // own source address
    input  wire logic                        rx_pause_valid,       // valid pause frame seen
    input  wire logic [15:0]                 rx_pause_value,       // its pause value
    input  wire logic                        tx_frame_busy,        // mac is sending a frame
    input  wire logic                        tx_frame_done,        // host frame done or aborted
    output logic                             tx_start,             // start host frame, pulse
    output logic                             tx_paused,            // pause counter running
    output logic                             rx_ctrl_deliver,      // hand pause frame to host
    output logic                             jam_active,           // send 55h preamble jam
    output logic                             pf_valid,             // pause frame byte valid
    output logic      [7:0]                  pf_data,              // pause frame byte
    output logic                             pf_last,              // last byte before crc
    input  wire logic                        pf_ready              // mac takes the byte
);
    import pause_fc_pkg::*;

    // ----------------------------------------------------------------------
    // state
    // ----------------------------------------------------------------------
    logic [1:0]  sel_q, sel_d;
    logic [7:0]  econ_q, econ_d, macon_q, macon_d, gap_q, gap_d;
    logic [7:0]  pv_lo_q, pv_lo_d, pv_hi_q, pv_hi_d, rdata_q, rdata_d;
    logic [15:0] pcnt_q, pcnt_d, frame_val_q, frame_val_d, per_cnt_q, per_cnt_d;
    logic [31:0] qcnt_q, qcnt_d, ptick_q, ptick_d;
    logic        inflight_q, inflight_d, start_q, start_d, deliver_q, deliver_d;
    logic        jam_q, jam_d, valid_q, valid_d, last_q, last_d;
    logic [7:0]  data_q, data_d;
    logic [5:0]  idx_q, idx_d;
    logic        paused_q, paused_d, pf_go;
    logic [15:0] go_val;
    pf_state_e   pf_q, pf_d;

    wire  [15:0] pause_value = {pv_hi_q, pv_lo_q};
    wire         tx_req      = econ_q[ECON_TX_REQ_BIT];
    wire         rx_take     = rx_pause_valid && macon_q[MACON_PAUSE_RECEIVE_ENABLE_BIT] && mac_full_duplex_cfg;
    wire         link_free   = !tx_frame_busy && !inflight_q && !start_q;
    // a host frame ready to go outranks the next periodic pause frame, else small values starve it
    wire         host_ready  = tx_req && pcnt_q == 16'h0000;

    // byte of the pause frame at a given index
    function automatic logic [7:0] frame_byte(input logic [5:0] i, input logic [15:0] v);
        logic [7:0] b;
        b = 8'h00;                                                   // padding
        if (i < OFS_SRC)
            b = 8'(PAUSE_DEST >> (6'(8) * (OFS_SRC - 6'h01 - i)));
        else if (i < OFS_TYPE)
            b = 8'(own_mac_addr >> (6'(8) * (OFS_TYPE - 6'h01 - i)));
        else if (i < OFS_OP)
            b = (i == OFS_TYPE) ? CTRL_TYPE[15:8] : CTRL_TYPE[7:0];
        else if (i < OFS_VAL)
            b = (i == OFS_OP) ? PAUSE_OP[15:8] : PAUSE_OP[7:0];
        else if (i < OFS_PAD)
            b = (i == OFS_VAL) ? v[15:8] : v[7:0];
        return b;
    endfunction

    // ----------------------------------------------------------------------
    // register file and transmit request
    // ----------------------------------------------------------------------
    always_comb begin
        sel_d    = sel_q;
        econ_d   = econ_q;
        macon_d  = macon_q;
        gap_d    = gap_q;
        pv_lo_d  = pv_lo_q;
        pv_hi_d  = pv_hi_q;
        // one-shot modes turn themselves off once their frame is out
        if (pf_q == PF_SEND && valid_q && pf_ready && last_q && sel_q != SEL_PERIODIC)
            sel_d = SEL_OFF;
        // request clears only once its frame has gone
        if (tx_frame_done && inflight_q)
            econ_d[ECON_TX_REQ_BIT] = 1'b0;
        // host writes come last so a same-cycle write wins over a hardware clear
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_FLOW_CTRL: sel_d   = reg_wdata[FC_SEL_HI_BIT:FC_SEL_LO_BIT];
                ADDR_ETH_CTRL1: econ_d  = reg_wdata;
                ADDR_MAC_CTRL1: macon_d = reg_wdata;
                ADDR_B2B_GAP:   gap_d   = reg_wdata & GAP_FIELD_MASK;
                ADDR_PAUSE_LO:  pv_lo_d = reg_wdata;
                ADDR_PAUSE_HI:  pv_hi_d = reg_wdata;
                default: ;
            endcase
        end
        // read path; unmapped indices and bits 7..3 of flow control read zero
        unique case (reg_addr)
            ADDR_FLOW_CTRL: rdata_d = {5'h00, mac_full_duplex_cfg, sel_q};
            ADDR_ETH_CTRL1: rdata_d = econ_q;
            ADDR_MAC_CTRL1: rdata_d = macon_q;
            ADDR_B2B_GAP:   rdata_d = gap_q;
            ADDR_PAUSE_LO:  rdata_d = pv_lo_q;
            ADDR_PAUSE_HI:  rdata_d = pv_hi_q;
            default:        rdata_d = REG_RESET;
        endcase
    end

    // ----------------------------------------------------------------------
    // pause timer for received pause frames
    // ----------------------------------------------------------------------
    always_comb begin
        pcnt_d    = pcnt_q;
        qcnt_d    = qcnt_q;
        deliver_d = rx_pause_valid && macon_q[MACON_FWD_BIT];
        // reception is never gated here; only starts of transmit are held
        if (rx_take) begin
            pcnt_d = rx_pause_value;
            qcnt_d = '0;
        end else if (pcnt_q != 16'h0000) begin
            if (qcnt_q == 32'(QUANTUM_CYC - 1)) begin
                qcnt_d = '0;
                pcnt_d = pcnt_q - 16'h0001;
            end else begin
                qcnt_d = qcnt_q + 32'h1;
            end
        end
        // registered copy so the paused output comes straight from a flop
        paused_d = (pcnt_d != 16'h0000);
    end

    // ----------------------------------------------------------------------
    // host frame start and half-duplex jam
    // ----------------------------------------------------------------------
    always_comb begin
        start_d    = 1'b0;
        inflight_d = inflight_q;
        // pause frames already queued get the link first; host frames wait for idle
        if (tx_req && pcnt_q == 16'h0000 && link_free && pf_q == PF_IDLE && !pf_go) begin
            start_d    = 1'b1;
            inflight_d = 1'b1;
        end
        if (tx_frame_done)
            inflight_d = 1'b0;
        // jam stops for our own request and restarts once that frame ends
        jam_d = !mac_full_duplex_cfg && sel_q[FC_SEL_LO_BIT] && !tx_req && !inflight_q;
    end

    // ----------------------------------------------------------------------
    // pause frame generator
    // ----------------------------------------------------------------------
    always_comb begin
        pf_go  = 1'b0;
        go_val = pause_value;
        ptick_d   = ptick_q;
        per_cnt_d = per_cnt_q;
        // periodic interval counted in quanta, half the programmed pause
        if (ptick_q == 32'(QUANTUM_CYC - 1)) begin
            ptick_d = '0;
            if (per_cnt_q != 16'h0000)
                per_cnt_d = per_cnt_q - 16'h0001;
        end else begin
            ptick_d = ptick_q + 32'h1;
        end
        if (mac_full_duplex_cfg && macon_q[MACON_PAUSE_TRANSMIT_ENABLE_BIT] && pf_q == PF_IDLE && link_free) begin
            unique case (sel_q)
                SEL_ONE:      pf_go = 1'b1;
                SEL_ZERO: begin
                    pf_go  = 1'b1;
                    go_val = 16'h0000;
                end
                SEL_PERIODIC: pf_go = (per_cnt_q == 16'h0000) && !host_ready;
                SEL_OFF:      pf_go = 1'b0;
            endcase
        end
        // a fresh selector write restarts the interval so periodic mode begins at once
        if (pf_go)
            per_cnt_d = (pause_value >> PERIOD_SHIFT) | 16'h0001;
        else if (reg_wr && reg_addr == ADDR_FLOW_CTRL)
            per_cnt_d = '0;
        pf_d        = pf_q;
        idx_d       = idx_q;
        valid_d     = valid_q;
        data_d      = data_q;
        last_d      = last_q;
        frame_val_d = frame_val_q;
        unique case (pf_q)
            PF_IDLE: if (pf_go) begin
                pf_d        = PF_SEND;
                frame_val_d = go_val;
                idx_d       = '0;
                valid_d     = 1'b1;
                data_d      = frame_byte(6'h00, go_val);
                last_d      = 1'b0;
            end
            PF_SEND: if (pf_ready) begin
                if (last_q) begin
                    pf_d    = PF_IDLE;
                    valid_d = 1'b0;
                    last_d  = 1'b0;
                end else begin
                    idx_d  = idx_q + 6'h01;
                    data_d = frame_byte(idx_q + 6'h01, frame_val_q);
                    last_d = (idx_q + 6'h01 == FRAME_BYTES - 6'h01);
                end
            end
        endcase
    end

    // ----------------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sel_q <= SEL_OFF;
            econ_q <= REG_RESET;
            macon_q <= REG_RESET;
            gap_q <= REG_RESET;
            pv_lo_q <= REG_RESET;
            pv_hi_q <= REG_RESET;
            rdata_q <= REG_RESET;
            pcnt_q <= '0;
            paused_q <= 1'b0;
            qcnt_q <= '0;
            ptick_q <= '0;
            per_cnt_q <= '0;
            frame_val_q <= '0;
            inflight_q <= 1'b0;
            start_q <= 1'b0;
            deliver_q <= 1'b0;
            jam_q <= 1'b0;
            valid_q <= 1'b0;
            last_q <= 1'b0;
            data_q <= 8'h00;
            idx_q <= '0;
            pf_q <= PF_IDLE;
        end else begin
            sel_q <= sel_d;
            econ_q <= econ_d;
            macon_q <= macon_d;
            gap_q <= gap_d;
            pv_lo_q <= pv_lo_d;
            pv_hi_q <= pv_hi_d;
            rdata_q <= rdata_d;
            pcnt_q <= pcnt_d;
            paused_q <= paused_d;
            qcnt_q <= qcnt_d;
            ptick_q <= ptick_d;
            per_cnt_q <= per_cnt_d;
            frame_val_q <= frame_val_d;
            inflight_q <= inflight_d;
            start_q <= start_d;
            deliver_q <= deliver_d;
            jam_q <= jam_d;
            valid_q <= valid_d;
            last_q <= last_d;
            data_q <= data_d;
            idx_q <= idx_d;
            pf_q <= pf_d;
        end
    end

    assign reg_rdata       = rdata_q;
    assign tx_start        = start_q;
    assign tx_paused       = paused_q;
    assign rx_ctrl_deliver = deliver_q;
    assign jam_active      = jam_q;
    assign pf_valid        = valid_q;
    assign pf_data         = data_q;
    assign pf_last         = last_q;

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_no_start_paused: assert property (start_q |-> $past(pcnt_q) == 16'h0000)
        else $error("host frame started while paused");
    a_pause_load: assert property (rx_take |=> pcnt_q == $past(rx_pause_value))
        else $error("pause counter not loaded");
    a_quantum_dec: assert property (!rx_take && pcnt_q != 0 && qcnt_q == 32'(QUANTUM_CYC - 1)
        |=> pcnt_q == $past(pcnt_q) - 16'h0001)
        else $error("pause counter missed a quantum");
    a_zero_resume: assert property (rx_take && rx_pause_value == 16'h0000 |=> !tx_paused)
        else $error("zero pause did not resume");
    a_req_held: assert property (tx_req && !reg_wr && !(tx_frame_done && inflight_q) |=> tx_req)
        else $error("request cleared before its frame ended");
    a_shadow_read: assert property (!reg_wr && reg_addr == ADDR_FLOW_CTRL
        |=> reg_rdata == {5'h00, $past(mac_full_duplex_cfg), $past(sel_q)})
        else $error("flow control readback wrong");
    a_frame_length: assert property (valid_q && pf_ready && last_q |-> idx_q == FRAME_BYTES - 6'h01)
        else $error("pause frame length wrong");
    a_zero_frame: assert property (pf_q == PF_SEND && sel_q == SEL_ZERO
        && (idx_q == OFS_VAL || idx_q == OFS_VAL + 6'h01) |-> data_q == 8'h00)
        else $error("final pause value not zero");
    a_hd_jam: assert property (!mac_full_duplex_cfg && sel_q == SEL_PERIODIC |=> !jam_q)
        else $error("jam with low selector bit clear");
    a_deliver: assert property (rx_pause_valid && macon_q[MACON_FWD_BIT] |=> rx_ctrl_deliver)
        else $error("pause frame not forwarded");
endmodule

/* File: testbench/far_end_mac.sv */
// far-side mac model: takes pause frame bytes and plays out host frames
`timescale 1ns/1ps
module far_end_mac (
    input  wire logic       ref_clk,        // 200 MHz clock
    input  wire logic       sys_rst,        // sync reset, high
    input  wire logic       slow,           // stall every other cycle
    input  wire logic       tx_start,       // start host frame
    input  wire logic       pf_valid,       // pause byte valid
    input  wire logic [7:0] pf_data,        // pause byte
    input  wire logic       pf_last,        // last byte before crc
    output logic            pf_ready,       // byte taken this edge
    output logic            tx_frame_busy,  // host frame on the wire
    output logic            tx_frame_done   // host frame finished
);
    logic [7:0]  frame_q [60];
    logic [5:0]  idx_q;
    logic [15:0] frames_q;
    logic [15:0] last_at_q;
    logic [15:0] starts_q;
    logic [3:0]  host_q;
    logic        toggle_q;

    // stalling on alternate cycles proves each byte stands until taken
    assign pf_ready      = !slow || toggle_q;
    assign tx_frame_busy = host_q != 4'h0;

    // byte capture and an eight-cycle host frame per start pulse
    always_ff @(posedge ref_clk) begin
        toggle_q      <= !toggle_q;
        tx_frame_done <= 1'b0;
        if (sys_rst) begin
            idx_q     <= 6'h00;
            toggle_q  <= 1'b0;
            frames_q  <= 16'h0000;
            last_at_q <= 16'h0000;
            starts_q  <= 16'h0000;
            host_q    <= 4'h0;
        end else begin
            if (pf_valid && pf_ready) begin
                frame_q[idx_q] <= pf_data;
                idx_q          <= pf_last ? 6'h00 : idx_q + 6'h01;
                if (pf_last) begin
                    last_at_q <= {10'h000, idx_q};
                    frames_q  <= frames_q + 16'h0001;
                end
            end
            if (tx_start) begin
                host_q   <= 4'h8;
                starts_q <= starts_q + 16'h0001;
            end else if (host_q == 4'h1) begin
                host_q        <= 4'h0;
                tx_frame_done <= 1'b1;
            end else if (host_q != 4'h0) begin
                host_q <= host_q - 4'h1;
            end
        end
    end
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the pause-frame flow-control block
`timescale 1ns/1ps
module testbench;
    import pause_fc_pkg::*;
    localparam int Q = 4;                   // short quantum keeps the run brief
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        reg_wr = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        fd = 1'b1;
    logic [47:0] own = 48'h021122334455;
    logic        rxv = 1'b0;
    logic [15:0] rx_val = 16'h0000;
    logic        slow = 1'b0;
    logic [7:0]  reg_rdata, pf_data;
    logic        busy, done, tx_start, tx_paused, deliver, jam, pf_valid, pf_last, pf_ready;
    logic [15:0] s;
    int          n;
    int          failures = 0;
    int          samples_checked = 0;
    // rows: index, write data, expected read back
    logic [18:0] rows [6] = '{{3'h3, 8'hFF, 8'h7F}, {3'h4, 8'hA5, 8'hA5}, {3'h5, 8'h5A, 8'h5A},
                              {3'h6, 8'hFF, 8'h00}, {3'h7, 8'h12, 8'h00}, {3'h0, 8'hF8, 8'h04}};

    pause_frame_flow_control #(.QUANTUM_CYC(Q)) pause_frame_flow_control_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mac_full_duplex_cfg(fd), .own_mac_addr(own),
        .rx_pause_valid(rxv), .rx_pause_value(rx_val), .tx_frame_busy(busy), .tx_frame_done(done),
        .tx_start(tx_start), .tx_paused(tx_paused), .rx_ctrl_deliver(deliver), .jam_active(jam),
        .pf_valid(pf_valid), .pf_data(pf_data), .pf_last(pf_last), .pf_ready(pf_ready));

    far_end_mac far_end_mac_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow), .tx_start(tx_start), .pf_valid(pf_valid),
        .pf_data(pf_data), .pf_last(pf_last), .pf_ready(pf_ready), .tx_frame_busy(busy),
        .tx_frame_done(done));

    always #2.5 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------------
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    // outputs are looked at mid-cycle, away from the launching edge; by reference so read then
    task automatic look(string name, logic [15:0] exp, const ref logic got);
        @(negedge ref_clk);
        chk(name, exp, {15'h0000, got});
        @(posedge ref_clk);
    endtask

    task automatic cyc(int k);
        repeat (k) @(posedge ref_clk);
    endtask

    task automatic wr(logic [2:0] a, logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(logic [2:0] a, logic [7:0] exp);
        reg_addr <= a;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk("register read", {8'h00, exp}, {8'h00, reg_rdata});
        @(posedge ref_clk);
    endtask

    task automatic pulse(logic [15:0] v);
        rxv <= 1'b1;
        rx_val <= v;
        @(posedge ref_clk);
        rxv <= 1'b0;
    endtask

    // waits for frame number cnt, then compares every byte of the last one
    task automatic frame(logic [15:0] cnt, logic [15:0] v);
        logic [143:0] hdr;
        hdr = {48'h0180C2000001, own, 32'h88080001, v};
        for (n = 0; n < 600 && far_end_mac_i.frames_q < cnt; n++) @(negedge ref_clk);
        chk("frame count", cnt, far_end_mac_i.frames_q);
        for (int i = 0; i < 60; i++) chk("pause byte", (i < 18) ? hdr[143-8*i -: 8] : 8'h00, far_end_mac_i.frame_q[i]);
        chk("last byte index", 16'd59, far_end_mac_i.last_at_q);
        @(posedge ref_clk);
    endtask

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------------
    initial begin
        cyc(20);
        sys_rst <= 1'b0;
        cyc(1);
        foreach (rows[i]) begin
            wr(rows[i][18:16], rows[i][15:8]);
            rd(rows[i][18:16], rows[i][7:0]);
        end
        wr(ADDR_MAC_CTRL1, 8'h0C);
        wr(ADDR_PAUSE_LO, 8'h34);
        wr(ADDR_PAUSE_HI, 8'h12);
        wr(ADDR_FLOW_CTRL, 8'h01);
        frame(16'd1, 16'h1234);
        rd(ADDR_FLOW_CTRL, 8'h04);
        slow <= 1'b1;
        wr(ADDR_FLOW_CTRL, 8'h03);
        frame(16'd2, 16'h0000);
        cyc(80);
        chk("one final frame", 16'd2, far_end_mac_i.frames_q);
        wr(ADDR_PAUSE_LO, 8'h04);
        wr(ADDR_PAUSE_HI, 8'h00);
        s = far_end_mac_i.starts_q;
        wr(ADDR_FLOW_CTRL, 8'h02);
        wr(ADDR_ETH_CTRL1, 8'h08);
        frame(16'd4, 16'h0004);
        chk("host frame beside pause", s + 16'd1, far_end_mac_i.starts_q);
        wr(ADDR_FLOW_CTRL, 8'h00);
        cyc(150);
        // received pause: load, reload, zero value
        pulse(16'h0002);
        look("paused", 16'd1, tx_paused);
        cyc(5);
        pulse(16'h0003);
        cyc(6);
        look("paused after reload", 16'd1, tx_paused);
        pulse(16'h0000);
        look("zero value resumes", 16'd0, tx_paused);
        // host request raised while paused must wait for expiry
        s = far_end_mac_i.starts_q;
        pulse(16'h0002);
        wr(ADDR_ETH_CTRL1, 8'h08);
        for (n = 0; n < 40 && tx_paused === 1'b1; n++) @(negedge ref_clk);
        chk("start while paused", s, far_end_mac_i.starts_q);
        chk("pause length", 16'd1, {15'h0000, n >= 3 && n <= 9});
        cyc(4);
        chk("start after pause", s + 16'd1, far_end_mac_i.starts_q);
        cyc(12);
        rd(ADDR_ETH_CTRL1, 8'h00);
        wr(ADDR_MAC_CTRL1, 8'h08);
        pulse(16'h0005);
        look("pause with receive off", 16'd0, tx_paused);
        wr(ADDR_MAC_CTRL1, 8'h06);
        pulse(16'h0000);
        look("forward pulse", 16'd1, deliver);
        // half duplex: only the low selector bit jams
        fd <= 1'b0;
        wr(ADDR_FLOW_CTRL, 8'h02);
        cyc(2);
        look("jam with 10", 16'd0, jam);
        rd(ADDR_FLOW_CTRL, 8'h02);
        wr(ADDR_FLOW_CTRL, 8'h03);
        cyc(2);
        look("jam with 11", 16'd1, jam);
        wr(ADDR_ETH_CTRL1, 8'h08);
        cyc(1);
        look("jam yields to own frame", 16'd0, jam);
        cyc(20);
        look("jam restarts", 16'd1, jam);
        // reset in mid-run clears everything again
        sys_rst <= 1'b1;
        cyc(3);
        sys_rst <= 1'b0;
        look("jam after reset", 16'd0, jam);
        for (int a = 0; a < 6; a++) rd(3'(a), 8'h00);
        complete_run();
    end

    // hang guard, well beyond the thousand or so cycles the run needs
    initial begin
        #100000;
        failures++;
        complete_run();
    end
endmodule
